// ---- hdl/pfs_pkg.sv ----
// constants for the upper pin function select block
package pfs_pkg;
	// config field width and field positions
	localparam int CFG_W            = 4;
	localparam int PC_CFG_W         = 8;
	localparam int PB_CFG_W         = 16;
	localparam int PC0_FIELD_LSB    = 0;
	localparam int PC1_FIELD_LSB    = 4;
	localparam int PB5_FIELD_LSB    = 4;
	localparam int PB6_FIELD_LSB    = 8;
	localparam int PB7_FIELD_LSB    = 12;
	localparam int DBG_GPIO_BIT     = 5;
	localparam int DBG_CFG_W        = 8;
	// pin configuration codes
	localparam logic [3:0] CFG_ANALOG   = 4'h0;
	localparam logic [3:0] CFG_OUT      = 4'h1;
	localparam logic [3:0] CFG_OUT_OD   = 4'h5;
	localparam logic [3:0] CFG_IN       = 4'h4;
	localparam logic [3:0] CFG_IN_PULL  = 4'h8;
	localparam logic [3:0] CFG_ALT_OUT  = 4'h9;
	localparam logic [3:0] CFG_ALT_OD   = 4'hd;
	// reset values
	localparam logic [7:0]  PC_CFG_RST  = 8'h44;
	localparam logic [15:0] PB_CFG_RST  = 16'h4444;
	localparam logic [7:0]  DBG_CFG_RST = 8'h00;
	// sync trace width codes from the core
	localparam logic [1:0] TW_1 = 2'h0;
	localparam logic [1:0] TW_2 = 2'h1;
	localparam logic [1:0] TW_4 = 2'h2;
	// digital pin count and select width
	localparam int NUM_PINS = 24;
	localparam int SEL_W    = 5;
	localparam logic [4:0] PIN_IDX_PB7 = 5'h0f;
	localparam logic [4:0] PIN_IDX_PC0 = 5'h10;
	// register indices on the plain port
	localparam logic [3:0] ADDR_PC_CFG = 4'h0;
	localparam logic [3:0] ADDR_PB_CFG = 4'h1;
	localparam logic [3:0] ADDR_DBG    = 4'h2;
	localparam logic [3:0] ADDR_INTC   = 4'h3;
	localparam logic [3:0] ADDR_INTD   = 4'h4;
	localparam logic [3:0] ADDR_STAT   = 4'h5;
	// debug mode after power-up
	typedef enum logic [0:0] {
		PFS_JTAG = 1'b0,
		PFS_SW   = 1'b1
	} pfs_dbg_mode_t;
endpackage

// ---- hdl/pfs_sync.sv ----
// two-flop synchroniser, one per bit
`timescale 1ns/1ns
module pfs_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	// data
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] stage1;

	generate
		if (W < 1) begin : g_bad
			$error("pfs_sync width must be positive");
		end
	endgenerate

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1   <= '0;
			sync_out <= '0;
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end
endmodule // pfs_sync

// ---- hdl/pfs_top.sv ----
// pin function select for port c pins 0-1 and port b pins 5-7
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
module pfs_top
	import pfs_pkg::*;
(
	// clock and reset
	input  wire logic                core_clk,
	input  wire logic                rst_n,
	// register port
	input  wire logic [3:0]          reg_addr,
	input  wire logic [31:0]         reg_wdata,
	input  wire logic                reg_write,
	input  wire logic                reg_read,
	output logic      [31:0]         reg_rdata,
	// core trace and debug state
	input  wire logic                trace_enable,
	input  wire logic                trace_async_sel,
	input  wire logic [1:0]          trace_width,
	input  wire logic                async_trace_out,
	input  wire logic                sync_trace_bit0,
	input  wire logic                sync_trace_bit1,
	input  wire logic                sw_select_seen,
	input  wire logic                external_reset_pin_n,
	// timer one
	input  wire logic [1:0]          timer_one_channel_output_enable,
	input  wire logic                timer_one_channel1,
	input  wire logic                timer_one_channel2,
	// gpio output data for the five pins: pb5, pb6, pb7, pc0, pc1
	input  wire logic [4:0]          gpio_out_data,
	// pad inputs, all digital pins
	input  wire logic [NUM_PINS-1:0] pad_in,
	// pad outputs for pb5, pb6, pb7, pc0, pc1
	output logic      [4:0]          pad_out,
	output logic      [4:0]          pad_oe,
	output logic      [4:0]          pad_pullup,
	output logic      [4:0]          pad_analog,
	// peripheral inputs
	output logic      [3:0]          analog_in_en,
	output logic                     debug_test_reset_in_n,
	output logic                     timer_one_capture1,
	output logic                     timer_one_capture2,
	output logic                     timer_two_ext_clock,
	output logic                     timer_one_clock_mask,
	output logic                     ext_int_b,
	output logic                     ext_int_c,
	output logic                     ext_int_d,
	output logic                     gpio_pc0_enabled
);
	// pad index within the five local pins, then within the 24-pin pad bus
	localparam int P_PB5 = 0;
	localparam int P_PB6 = 1;
	localparam int P_PB7 = 2;
	localparam int P_PC0 = 3;
	localparam int P_PC1 = 4;
	localparam int PB5_IDX = 13;
	localparam int PB6_IDX = 14;
	localparam int PB7_IDX = 15;
	localparam int PC0_IDX = 16;

	generate
		if (NUM_PINS > (1 << SEL_W)) begin : g_bad
			$error("pin select too narrow");
		end
	endgenerate

	// synchronised pads and reset pin
	logic [NUM_PINS-1:0] pad_s;
	logic                ext_rst_s;

	pfs_sync #(.W(NUM_PINS)) u_pad_sync (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.async_in (pad_in),
		.sync_out (pad_s)
	);

	pfs_sync #(.W(1)) u_rst_sync (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.async_in (~external_reset_pin_n),
		.sync_out (ext_rst_s)
	);

	// configuration registers
	logic [PC_CFG_W-1:0]  port_c_low_config, next_port_c_low_config;
	logic [PB_CFG_W-1:0]  port_b_high_config, next_port_b_high_config;
	logic [DBG_CFG_W-1:0] debug_pin_config, next_debug_pin_config;
	logic [SEL_W-1:0]     ext_int_c_pin_select, next_ext_int_c_pin_select;
	logic [SEL_W-1:0]     ext_int_d_pin_select, next_ext_int_d_pin_select;
	pfs_dbg_mode_t        dbg_mode, next_dbg_mode;
	logic [31:0]          next_reg_rdata;

	always_comb begin
		next_port_c_low_config    = port_c_low_config;
		next_port_b_high_config   = port_b_high_config;
		next_debug_pin_config     = debug_pin_config;
		next_ext_int_c_pin_select = ext_int_c_pin_select;
		next_ext_int_d_pin_select = ext_int_d_pin_select;
		next_reg_rdata            = 32'h0000_0000;
		if (reg_write) begin
			case (reg_addr)
				ADDR_PC_CFG: next_port_c_low_config    = reg_wdata[PC_CFG_W-1:0];
				ADDR_PB_CFG: next_port_b_high_config   = reg_wdata[PB_CFG_W-1:0];
				ADDR_DBG:    next_debug_pin_config     = reg_wdata[DBG_CFG_W-1:0];
				ADDR_INTC:   next_ext_int_c_pin_select = reg_wdata[SEL_W-1:0];
				ADDR_INTD:   next_ext_int_d_pin_select = reg_wdata[SEL_W-1:0];
				default:     ;
			endcase
		end
		if (reg_read) begin
			case (reg_addr)
				ADDR_PC_CFG: next_reg_rdata = {24'h000000, port_c_low_config};
				ADDR_PB_CFG: next_reg_rdata = {16'h0000, port_b_high_config};
				ADDR_DBG:    next_reg_rdata = {24'h000000, debug_pin_config};
				ADDR_INTC:   next_reg_rdata = {27'h0000000, ext_int_c_pin_select};
				ADDR_INTD:   next_reg_rdata = {27'h0000000, ext_int_d_pin_select};
				ADDR_STAT:   next_reg_rdata = {31'h00000000, dbg_mode};
				default:     next_reg_rdata = 32'h0000_0000;
			endcase
		end
	end

	// jtag after power-up or reset pin low; sw only on protocol
	always_comb begin
		next_dbg_mode = dbg_mode;
		case (dbg_mode)
			PFS_JTAG: if (sw_select_seen) next_dbg_mode = PFS_SW;
			PFS_SW:   next_dbg_mode = PFS_SW;
			default:  next_dbg_mode = PFS_JTAG;
		endcase
		if (ext_rst_s)
			next_dbg_mode = PFS_JTAG;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			port_c_low_config    <= PC_CFG_RST;
			port_b_high_config   <= PB_CFG_RST;
			debug_pin_config     <= DBG_CFG_RST;
			ext_int_c_pin_select <= PIN_IDX_PB7;
			ext_int_d_pin_select <= PIN_IDX_PC0;
			dbg_mode             <= PFS_JTAG;
			reg_rdata            <= 32'h0000_0000;
		end else begin
			port_c_low_config    <= next_port_c_low_config;
			port_b_high_config   <= next_port_b_high_config;
			debug_pin_config     <= next_debug_pin_config;
			ext_int_c_pin_select <= next_ext_int_c_pin_select;
			ext_int_d_pin_select <= next_ext_int_d_pin_select;
			dbg_mode             <= next_dbg_mode;
			reg_rdata            <= next_reg_rdata;
		end
	end

	// per-pin fields
	logic [CFG_W-1:0] cfg [5];
	assign cfg[P_PB5] = port_b_high_config[PB5_FIELD_LSB +: CFG_W];
	assign cfg[P_PB6] = port_b_high_config[PB6_FIELD_LSB +: CFG_W];
	assign cfg[P_PB7] = port_b_high_config[PB7_FIELD_LSB +: CFG_W];
	assign cfg[P_PC0] = port_c_low_config[PC0_FIELD_LSB +: CFG_W];
	assign cfg[P_PC1] = port_c_low_config[PC1_FIELD_LSB +: CFG_W];

	// trace decode
	logic trace_bit1_on, dbg_gpio;
	logic [4:0] alt_val, alt_ok;
	always_comb begin
		trace_bit1_on = trace_enable && !trace_async_sel &&
			(trace_width == TW_2 || trace_width == TW_4);
		dbg_gpio = debug_pin_config[DBG_GPIO_BIT];
		alt_val = 5'h00;
		alt_ok  = 5'h00;
		alt_val[P_PB5] = 1'b0;
		alt_val[P_PB6] = timer_one_channel1;
		alt_ok[P_PB6]  = timer_one_channel_output_enable[0];
		alt_val[P_PB7] = timer_one_channel2;
		alt_ok[P_PB7]  = timer_one_channel_output_enable[1];
		alt_val[P_PC0] = sync_trace_bit1;
		alt_ok[P_PC0]  = trace_bit1_on;
		if (trace_enable && trace_async_sel) begin
			alt_val[P_PC1] = async_trace_out;
			alt_ok[P_PC1]  = 1'b1;
		end else begin
			alt_val[P_PC1] = sync_trace_bit0;
			alt_ok[P_PC1]  = trace_enable && (trace_width == TW_1 ||
				trace_width == TW_2 || trace_width == TW_4);
		end
	end

	// pc0 owned by debug in jtag or trace bit1 unless dbg_gpio is set, gpio otherwise
	logic pc0_is_gpio, pc0_is_debug_test_reset_in;
	always_comb begin
		pc0_is_gpio = dbg_gpio || (dbg_mode == PFS_SW && !trace_bit1_on);
		pc0_is_debug_test_reset_in = !dbg_gpio && dbg_mode == PFS_JTAG && !trace_bit1_on;
	end

	// one source per pin, priority fixed by the config field
	logic [4:0] next_pad_out, next_pad_oe, next_pad_pullup, next_pad_analog;
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			next_pad_out[i]    = 1'b0;
			next_pad_oe[i]     = 1'b0;
			next_pad_pullup[i] = 1'b0;
			next_pad_analog[i] = 1'b0;
			case (cfg[i])
				CFG_ANALOG:  next_pad_analog[i] = 1'b1;
				CFG_OUT: begin
					next_pad_out[i] = gpio_out_data[i];
					next_pad_oe[i]  = 1'b1;
				end
				CFG_OUT_OD: begin
					next_pad_out[i] = 1'b0;
					next_pad_oe[i]  = !gpio_out_data[i];
				end
				CFG_IN_PULL: next_pad_pullup[i] = gpio_out_data[i];
				CFG_ALT_OUT: begin
					next_pad_out[i] = alt_val[i];
					next_pad_oe[i]  = alt_ok[i];
				end
				CFG_ALT_OD: begin
					next_pad_out[i] = 1'b0;
					next_pad_oe[i]  = alt_ok[i] && !alt_val[i];
				end
				default: ;
			endcase
		end
		// debug ownership of pc0 overrides the gpio path
		if (!pc0_is_gpio && !(cfg[P_PC0] inside {CFG_ALT_OUT, CFG_ALT_OD} && trace_bit1_on)) begin
			next_pad_out[P_PC0] = 1'b0;
			next_pad_oe[P_PC0]  = 1'b0;
		end
		if (pc0_is_debug_test_reset_in) begin
			next_pad_pullup[P_PC0] = 1'b1;
			next_pad_analog[P_PC0] = 1'b0;
		end
	end

	// peripheral inputs; captures and int b fixed, int c/d selectable
	logic [3:0] next_analog_in_en;
	always_comb begin
		next_analog_in_en[3] = cfg[P_PC1] == CFG_ANALOG;
		next_analog_in_en[2] = cfg[P_PB7] == CFG_ANALOG;
		next_analog_in_en[1] = cfg[P_PB6] == CFG_ANALOG;
		next_analog_in_en[0] = cfg[P_PB5] == CFG_ANALOG;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pad_out               <= 5'h00;
			pad_oe                <= 5'h00;
			pad_pullup            <= 5'h00;
			pad_analog            <= 5'h00;
			analog_in_en          <= 4'h0;
			debug_test_reset_in_n <= 1'b1;
			timer_one_capture1    <= 1'b0;
			timer_one_capture2    <= 1'b0;
			timer_two_ext_clock   <= 1'b0;
			timer_one_clock_mask  <= 1'b0;
			ext_int_b             <= 1'b0;
			ext_int_c             <= 1'b0;
			ext_int_d             <= 1'b0;
			gpio_pc0_enabled      <= 1'b0;
		end else begin
			pad_out               <= next_pad_out;
			pad_oe                <= next_pad_oe;
			pad_pullup            <= next_pad_pullup;
			pad_analog            <= next_pad_analog;
			analog_in_en          <= next_analog_in_en;
			debug_test_reset_in_n <= pc0_is_debug_test_reset_in ? pad_s[PC0_IDX] : 1'b1;
			timer_one_capture1    <= pad_s[PB6_IDX];
			timer_one_capture2    <= pad_s[PB7_IDX];
			timer_two_ext_clock   <= pad_s[PB5_IDX];
			timer_one_clock_mask  <= pad_s[PB5_IDX];
			ext_int_b             <= pad_s[PB6_IDX];
			ext_int_c             <= (32'(ext_int_c_pin_select) < NUM_PINS) ?
				pad_s[ext_int_c_pin_select] : 1'b0;
			ext_int_d             <= (32'(ext_int_d_pin_select) < NUM_PINS) ?
				pad_s[ext_int_d_pin_select] : 1'b0;
			gpio_pc0_enabled      <= pc0_is_gpio;
		end
	end

	// analog pins never drive
	chk_analog_no_drive: assert property (@(posedge core_clk) disable iff (!rst_n)
		(cfg[P_PC1] == CFG_ANALOG) |=> (!pad_oe[P_PC1] && analog_in_en[3]))
		else $error("pc1 analog but driven");
	chk_pb_analog_map: assert property (@(posedge core_clk) disable iff (!rst_n)
		(cfg[P_PB7] == CFG_ANALOG) |=> analog_in_en[2] && pad_analog[P_PB7])
		else $error("pb7 analog not mapped");
	chk_timer_out_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
		(!timer_one_channel_output_enable[0] && cfg[P_PB6] == CFG_ALT_OUT)
		|=> !pad_oe[P_PB6])
		else $error("timer ch1 driven while disabled");
	chk_async_trace: assert property (@(posedge core_clk) disable iff (!rst_n)
		(trace_enable && trace_async_sel && cfg[P_PC1] == CFG_ALT_OUT)
		|=> pad_oe[P_PC1] && pad_out[P_PC1] == $past(async_trace_out))
		else $error("async trace not on pc1");
	chk_sync_bit0: assert property (@(posedge core_clk) disable iff (!rst_n)
		(!trace_enable && cfg[P_PC1] == CFG_ALT_OUT) |=> !pad_oe[P_PC1])
		else $error("pc1 trace driven while off");
	chk_trace_bit1: assert property (@(posedge core_clk) disable iff (!rst_n)
		(trace_enable && !trace_async_sel && trace_width == TW_1)
		|=> !pad_oe[P_PC0] || gpio_pc0_enabled)
		else $error("bit1 driven in one-wire mode");
	chk_debug_test_reset_in_pull: assert property (@(posedge core_clk) disable iff (!rst_n)
		pc0_is_debug_test_reset_in |=> pad_pullup[P_PC0] && !pad_oe[P_PC0])
		else $error("test reset pin not pulled up");
	chk_int_b_fixed: assert property (@(posedge core_clk) disable iff (!rst_n)
		ext_int_b == $past(pad_s[PB6_IDX]) && timer_one_capture1 == ext_int_b)
		else $error("int b not from pb6");
	chk_gpio_pc0: assert property (@(posedge core_clk) disable iff (!rst_n)
		(dbg_mode == PFS_SW && !trace_bit1_on) |=> gpio_pc0_enabled)
		else $error("pc0 not gpio in sw mode");
	chk_mode_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
		ext_rst_s |=> dbg_mode == PFS_JTAG)
		else $error("reset pin did not restore jtag");
endmodule // pfs_top

// ---- testbench/pfs_partner.sv ----
// board and debugger model standing at the upper pin group
`timescale 1ns/1ns
module pfs_partner (
	// clock
	input  wire logic        core_clk,
	// device pads, order pb5, pb6, pb7, pc0, pc1
	input  wire logic [4:0]  pad_out,
	input  wire logic [4:0]  pad_oe,
	input  wire logic [4:0]  pad_pullup,
	// board levels and debugger presence
	input  wire logic [23:0] board,
	input  wire logic        dbg_attached,
	// levels seen by the device
	output logic      [23:0] pad_in,
	output logic             sw_select_seen,
	output logic             external_reset_pin_n
);
	logic tog;

	initial begin
		tog = 1'b0;
		sw_select_seen = 1'b0;
		external_reset_pin_n = 1'b1;
	end

	always @(posedge core_clk) tog <= ~tog;

	// a driven pad wins over the board, except pc1 which is not fed back
	always_comb begin
		pad_in = board;
		for (int i = 0; i < 4; i++) begin
			if (pad_oe[i]) pad_in[13 + i] = pad_out[i];
		end
		// unplugged debugger: line floats to its pull-up, else wanders
		if (!pad_oe[3] && !dbg_attached) pad_in[16] = pad_pullup[3] ? 1'b1 : tog;
	end

	// debugger finishes its mode selection sequence
	task automatic select_sw();
		@(posedge core_clk);
		sw_select_seen <= 1'b1;
		@(posedge core_clk);
		sw_select_seen <= 1'b0;
	endtask

	task automatic pulse_reset_pin();
		@(posedge core_clk);
		external_reset_pin_n <= 1'b0;
		repeat (4) @(posedge core_clk);
		external_reset_pin_n <= 1'b1;
	endtask
endmodule // pfs_partner

// ---- testbench/pfs_top_tb.sv ----
// self-checking bench for the upper pin function select block
`timescale 1ns/1ns
module pfs_top_tb;
	import pfs_pkg::*;
	typedef struct {logic [3:0] sel; logic [31:0] exp; logic [31:0] msk;} pfs_note_t;
	logic        core_clk, rst_n, reg_write, reg_read, look, rd_look, dbg_attached;
	logic [3:0]  reg_addr, analog_in_en;
	logic [31:0] reg_wdata, reg_rdata;
	logic        trace_enable, trace_async_sel, async_trace_out, sync_trace_bit0;
	logic        sync_trace_bit1, timer_one_channel1, timer_one_channel2;
	logic [1:0]  trace_width, timer_one_channel_output_enable;
	logic        sw_select_seen, external_reset_pin_n, debug_test_reset_in_n;
	logic        timer_one_capture1, timer_one_capture2, timer_two_ext_clock;
	logic        timer_one_clock_mask, ext_int_b, ext_int_c, ext_int_d, gpio_pc0_enabled;
	logic [4:0]  gpio_out_data, pad_out, pad_oe, pad_pullup, pad_analog;
	logic [23:0] pad_in, board;
	logic [8:0]  misc;
	logic        en, b1;
	pfs_note_t   cur;
	pfs_note_t   notes[$];
	int          failures = 0;
	int          checked = 0;
	int          cycles = 0;
	logic [31:0] rst_exp[7] = '{32'h44, 32'h4444, 32'h0, 32'hf, 32'h10, 32'h0, 32'h0};

	assign misc = {debug_test_reset_in_n, timer_one_capture1, timer_one_capture2,
		timer_two_ext_clock, timer_one_clock_mask, ext_int_b, ext_int_c, ext_int_d,
		gpio_pc0_enabled};

	pfs_top u_pfs_top (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
		.reg_rdata, .trace_enable, .trace_async_sel, .trace_width, .async_trace_out,
		.sync_trace_bit0, .sync_trace_bit1, .sw_select_seen, .external_reset_pin_n,
		.timer_one_channel_output_enable, .timer_one_channel1, .timer_one_channel2,
		.gpio_out_data, .pad_in, .pad_out, .pad_oe, .pad_pullup, .pad_analog,
		.analog_in_en, .debug_test_reset_in_n, .timer_one_capture1, .timer_one_capture2,
		.timer_two_ext_clock, .timer_one_clock_mask, .ext_int_b, .ext_int_c, .ext_int_d,
		.gpio_pc0_enabled);

	pfs_partner u_pfs_partner (.core_clk, .pad_out, .pad_oe, .pad_pullup, .board,
		.dbg_attached, .pad_in, .sw_select_seen, .external_reset_pin_n);

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic finish_test();
		if (failures == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	function automatic logic [31:0] seen(input logic [3:0] s);
		case (s)
			4'h0: return reg_rdata;
			4'h1: return {27'h0, pad_out};
			4'h2: return {27'h0, pad_oe};
			4'h3: return {27'h0, pad_pullup};
			4'h4: return {28'h0, analog_in_en};
			4'h6: return {27'h0, pad_analog};
			default: return {23'h0, misc};
		endcase
	endfunction

	// watcher: read data stands only in the cycle after the strobe
	always @(posedge core_clk) begin
		rd_look <= reg_read;
		if (rd_look === 1'b1 || look === 1'b1) begin
			cur = notes.pop_front();
			check(seen(cur.sel) & cur.msk, cur.exp & cur.msk);
		end
	end

	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			failures++;
			finish_test();
		end
	end

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge core_clk);
		reg_write <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		notes.push_back('{4'h0, e, 32'hffffffff});
		@(posedge core_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge core_clk);
		reg_read <= 1'b0;
	endtask

	task automatic want(input logic [3:0] s, input logic [31:0] e, input logic [31:0] m);
		notes.push_back('{s, e, m});
		@(posedge core_clk);
		look <= 1'b1;
		@(posedge core_clk);
		look <= 1'b0;
	endtask

	// covers two sync flops plus the output register
	task automatic settle();
		repeat (4) @(posedge core_clk);
	endtask

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	initial begin
		void'($urandom(32'hfc30cd70));
		{rst_n, reg_write, reg_read, look, trace_enable, trace_async_sel} = '0;
		{async_trace_out, sync_trace_bit0, sync_trace_bit1, trace_width} = '0;
		{timer_one_channel_output_enable, timer_one_channel1, timer_one_channel2} = '0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		dbg_attached = 1'b1;
		board = 24'($urandom);
		gpio_out_data = 5'($urandom);
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		wr(4'h6, 32'hffffffff);
		foreach (rst_exp[i]) rd(i[3:0], rst_exp[i]);
		wr(ADDR_PC_CFG, 32'h04);
		wr(ADDR_PB_CFG, 32'h0);
		settle();
		want(4'h4, 32'hf, 32'hf);
		wr(ADDR_PB_CFG, 32'h0404);
		settle();
		want(4'h4, 32'hd, 32'hf);
		want(4'h6, 32'h15, 32'h1f);
		// async, then widths 1, 2, 4, then trace switched off
		wr(ADDR_PC_CFG, 32'h99);
		wr(ADDR_PB_CFG, 32'h4444);
		for (int k = 0; k < 5; k++) begin
			trace_enable <= (k != 4);
			trace_async_sel <= (k == 0);
			trace_width <= (k == 1) ? TW_1 : (k == 2) ? TW_2 : TW_4;
			{async_trace_out, sync_trace_bit0, sync_trace_bit1} <= 3'($urandom);
			settle();
			en = (k != 4);
			b1 = en && k > 1;
			want(4'h2, {27'h0, en, b1, 3'h0}, 32'h1f);
			want(4'h1, {27'h0, k == 0 ? async_trace_out : sync_trace_bit0,
				sync_trace_bit1, 3'h0}, {27'h0, en, b1, 3'h0});
		end
		wr(ADDR_PC_CFG, 32'h44);
		wr(ADDR_PB_CFG, 32'h9940);
		repeat (4) begin
			{timer_one_channel_output_enable, timer_one_channel1, timer_one_channel2}
				<= 4'($urandom);
			settle();
			want(4'h2, {29'h0, timer_one_channel_output_enable, 1'b0}, 32'h1f);
			want(4'h1, {29'h0, timer_one_channel2, timer_one_channel1, 1'b0},
				{29'h0, timer_one_channel_output_enable, 1'b0});
		end
		// plain out, open drain, pulled input, alternate open drain
		wr(ADDR_PC_CFG, 32'hd4);
		wr(ADDR_PB_CFG, 32'h8514);
		trace_enable <= 1'b1;
		trace_async_sel <= 1'b1;
		gpio_out_data <= 5'($urandom);
		settle();
		want(4'h2, {27'h0, !async_trace_out, 2'b00, !gpio_out_data[1], 1'b1},
			32'h1f);
		want(4'h1, {31'h0, gpio_out_data[0]}, 32'h1f);
		want(4'h3, {29'h0, gpio_out_data[2], 2'b00}, 32'h07);
		trace_enable <= 1'b0;
		wr(ADDR_PC_CFG, 32'h44);
		wr(ADDR_PB_CFG, 32'h4444);
		repeat (4) begin
			board <= 24'($urandom);
			settle();
			want(4'h5, {23'h0, board[16], board[14], board[15], board[13], board[13],
				board[14], board[15], board[16], 1'b0}, 32'h1ff);
		end
		want(4'h3, 32'h8, 32'h8);
		wr(ADDR_INTC, 32'hd);
		wr(ADDR_INTD, 32'h18);
		settle();
		rd(ADDR_INTC, 32'hd);
		want(4'h5, {29'h0, board[13], 2'b00}, 32'h6);
		dbg_attached <= 1'b0;
		settle();
		want(4'h5, 32'h100, 32'h100);
		dbg_attached <= 1'b1;
		wr(ADDR_DBG, 32'h20);
		settle();
		want(4'h5, 32'h101, 32'h101);
		wr(ADDR_DBG, 32'h0);
		u_pfs_partner.select_sw();
		settle();
		rd(ADDR_STAT, 32'h1);
		want(4'h5, 32'h101, 32'h101);
		u_pfs_partner.pulse_reset_pin();
		settle();
		rd(ADDR_STAT, 32'h0);
		want(4'h5, {23'h0, board[16], 8'h0}, 32'h101);
		repeat (4) @(posedge core_clk);
		finish_test();
	end
endmodule // pfs_top_tb
